// ---- src/bidir_fifo_pkg.sv ----
package bidir_fifo_pkg;

  // Port data width and queue depth
  localparam int unsigned DATA_W = 36;
  localparam int unsigned QUEUE_DEPTH = 8;

  // Width of the near-empty and near-full offset values
  localparam int unsigned OFS_W = 14;

  // Preset offsets chosen by the latched offset select code
  localparam logic [13:0] OFS_PRESET_01 = 14'h0008;
  localparam logic [13:0] OFS_PRESET_10 = 14'h0010;
  localparam logic [13:0] OFS_PRESET_11 = 14'h0040;

  // Reset value of every offset value before programming
  localparam logic [13:0] OFS_RESET = 14'h0008;

  // Number of port A writes consumed by parallel offset loading
  localparam logic [2:0] PROG_WORDS = 3'h4;

  // Slot of each offset value, in the order the loading writes fill them
  localparam logic [1:0] OFS_AB_FULL = 2'h0;
  localparam logic [1:0] OFS_AB_EMPTY = 2'h1;
  localparam logic [1:0] OFS_BA_FULL = 2'h2;
  localparam logic [1:0] OFS_BA_EMPTY = 2'h3;

endpackage

// ---- src/bidir_sync_fifo_ports.sv ----
// Behaviour
// - Queue flags change only on own port clock.
// - Select low enables transfers; high floats data.
// - Qualifier high required for any transfer.
// - Port A dir high writes; drives only reading.
// - Port B dir low writes; drives only reading.
// - Port A empty/ready: empty or output valid.
// - Port B empty/ready: empty or output valid.
// - Port A full/ready: full or room left.
// - Port B full/ready: full or room left.
// - Reset release latches offset select; preset offsets.
// - Joint reset, selects low: four offset loads.
// - Port A box select picks mailbox or queue.
// - Port B box select picks mailbox or queue.
// - Port A mailbox write clears its flag; blocks.
// - Port B mailbox read or reset sets flag.
// - Port B mailbox write clears its flag; blocks.
// - Port A mailbox read or reset sets flag.
// - A-to-B reset clears pointers, port B output.
// - B-to-A reset clears pointers, port A output.
// - Rewind strobe returns read pointer, standard only.
// - Fall-through select high means standard mode.
// - Offset loads ordered: ab full, ab empty, ba.
// - Near flags low at or below their offsets.
// - Port A queue write needs all qualifiers, room.
`timescale 1ns/100ps

module sync_fifo #(
  parameter int unsigned WIDTH = 36,
  parameter int unsigned DEPTH = 8,
  parameter int unsigned AW = $clog2(DEPTH)
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_clear,
  input wire logic i_rewind,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [WIDTH-1:0] i_wr_data,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [WIDTH-1:0] o_rd_data,
  output logic [AW:0] o_count
);
  // Depth must be a power of two; a rewind after the write pointer wrapped replays garbage
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;

  assign o_count = wr_ptr_reg - rd_ptr_reg;
  assign o_wr_ready = (o_count != (AW+1)'(DEPTH)) && !i_clear;
  assign o_rd_valid = (o_count != '0) && !i_clear;
  assign o_rd_data = mem[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr_reg <= '0;
    end else if (i_clear) begin
      wr_ptr_reg <= '0;
    end else if (i_wr_valid && o_wr_ready) begin
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_ptr_reg <= '0;
    end else if (i_clear || i_rewind) begin
      rd_ptr_reg <= '0;
    end else if (o_rd_valid && i_rd_ready) begin
      rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_wr_valid && o_wr_ready) begin
      mem[wr_ptr_reg[AW-1:0]] <= i_wr_data;
    end
  end
endmodule

module bidir_sync_fifo_ports #(
  parameter int unsigned DEPTH = bidir_fifo_pkg::QUEUE_DEPTH,
  parameter logic [13:0] PRESET_01 = bidir_fifo_pkg::OFS_PRESET_01,
  parameter logic [13:0] PRESET_10 = bidir_fifo_pkg::OFS_PRESET_10,
  parameter logic [13:0] PRESET_11 = bidir_fifo_pkg::OFS_PRESET_11
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_port_a_clock,
  input wire logic i_port_b_clock,
  input wire logic i_port_a_select_n,
  input wire logic i_port_b_select_n,
  input wire logic i_port_a_go,
  input wire logic i_port_b_go,
  input wire logic i_port_a_dir,
  input wire logic i_port_b_dir,
  input wire logic i_port_a_box_sel,
  input wire logic i_port_b_box_sel,
  input wire logic [35:0] i_port_a_data,
  output logic [35:0] o_port_a_data,
  output logic o_port_a_data_oe,
  input wire logic [35:0] i_port_b_data,
  output logic [35:0] o_port_b_data,
  output logic o_port_b_data_oe,
  input wire logic i_ab_master_reset_n,
  input wire logic i_ba_master_reset_n,
  input wire logic i_ab_rewind_n,
  input wire logic i_ba_rewind_n,
  input wire logic i_offset_sel_lo,
  input wire logic i_offset_sel_hi,
  input wire logic i_fall_through_select,
  output logic o_port_a_empty_or_ready,
  output logic o_port_b_empty_or_ready,
  output logic o_port_a_full_or_ready,
  output logic o_port_b_full_or_ready,
  output logic o_port_a_near_full_n,
  output logic o_port_b_near_full_n,
  output logic o_port_a_near_empty_n,
  output logic o_port_b_near_empty_n,
  output logic o_ab_box_full_n,
  output logic o_ba_box_full_n
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned W = bidir_fifo_pkg::DATA_W;
  localparam int unsigned OW = bidir_fifo_pkg::OFS_W;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  // Port clocks are sampled as ordinary inputs; they must be well below half of i_clk
  logic a_clk_q;
  logic b_clk_q;
  logic a_edge;
  logic b_edge;
  logic a_act;
  logic b_act;
  logic [1:0] sel_code;
  logic prog;
  logic prog_wr;
  logic [2:0] prog_cnt_reg;
  logic [OW-1:0] ofs_reg [4];

  // Index 0 is the a_to_b direction, index 1 the b_to_a direction
  logic wr_edge [2];
  logic rd_edge [2];
  logic wr_act [2];
  logic rd_act [2];
  logic wr_box [2];
  logic rd_box [2];
  logic [W-1:0] wr_data [2];
  logic mrst_n [2];
  logic mrst_q [2];
  logic mrst_rise [2];
  logic rew_q [2];
  logic std_reg [2];
  logic q_wr [2];
  logic rd_req [2];
  logic pop [2];
  logic rd_valid [2];
  logic [W-1:0] rd_data [2];
  logic [AW:0] cnt [2];
  logic [AW:0] cnt_rd_after [2];
  logic [AW:0] cnt_wr_after [2];
  logic [W-1:0] out_reg [2];
  logic [W-1:0] box_reg [2];
  logic box_full_n_reg [2];
  logic er_reg [2];
  logic fr_reg [2];
  logic ne_n_reg [2];
  logic nf_n_reg [2];

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      a_clk_q <= 1'b0;
      b_clk_q <= 1'b0;
    end else begin
      a_clk_q <= i_port_a_clock;
      b_clk_q <= i_port_b_clock;
    end
  end

  assign a_edge = i_port_a_clock && !a_clk_q;
  assign b_edge = i_port_b_clock && !b_clk_q;
  assign a_act = a_edge && !i_port_a_select_n && i_port_a_go;
  assign b_act = b_edge && !i_port_b_select_n && i_port_b_go;

  assign wr_edge[0] = a_edge;
  assign rd_edge[0] = b_edge;
  assign wr_edge[1] = b_edge;
  assign rd_edge[1] = a_edge;
  assign wr_act[0] = a_act && i_port_a_dir;
  assign rd_act[1] = a_act && !i_port_a_dir;
  assign wr_act[1] = b_act && !i_port_b_dir;
  assign rd_act[0] = b_act && i_port_b_dir;
  assign wr_box[0] = i_port_a_box_sel;
  assign rd_box[1] = i_port_a_box_sel;
  assign wr_box[1] = i_port_b_box_sel;
  assign rd_box[0] = i_port_b_box_sel;
  assign wr_data[0] = i_port_a_data;
  assign wr_data[1] = i_port_b_data;
  assign mrst_n[0] = i_ab_master_reset_n;
  assign mrst_n[1] = i_ba_master_reset_n;

  // Offset loading and presets
  assign sel_code = {i_offset_sel_hi, i_offset_sel_lo};
  assign prog = prog_cnt_reg != 3'h0;
  assign prog_wr = prog && wr_act[0] && !wr_box[0] && fr_reg[0];

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prog_cnt_reg <= 3'h0;
    end else if (mrst_rise[0] && mrst_rise[1] && sel_code == 2'h0) begin
      prog_cnt_reg <= bidir_fifo_pkg::PROG_WORDS;
    end else if (!mrst_n[0] || !mrst_n[1]) begin
      prog_cnt_reg <= 3'h0;
    end else if (prog_wr) begin
      prog_cnt_reg <= prog_cnt_reg - 3'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < 4; i++) begin
        ofs_reg[i] <= bidir_fifo_pkg::OFS_RESET;
      end
    end else if (prog_wr) begin
      // Slot order follows the count of loads still outstanding
      ofs_reg[2'(bidir_fifo_pkg::PROG_WORDS - prog_cnt_reg)] <= wr_data[0][OW-1:0];
    end else begin
      for (int d = 0; d < 2; d++) begin
        if (mrst_rise[d] && sel_code != 2'h0) begin
          ofs_reg[2*d] <= (sel_code == 2'h1) ? PRESET_01 : (sel_code == 2'h2) ? PRESET_10 : PRESET_11;
          ofs_reg[2*d+1] <= (sel_code == 2'h1) ? PRESET_01 : (sel_code == 2'h2) ? PRESET_10 : PRESET_11;
        end
      end
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_dir
    assign mrst_rise[g] = mrst_n[g] && !mrst_q[g];
    // Port A writes during offset loading never reach the queue
    assign q_wr[g] = wr_act[g] && !wr_box[g] && fr_reg[g] && !(g == 0 && prog);
    assign rd_req[g] = rd_act[g] && !rd_box[g] && er_reg[g];
    // Fall-through refills the output register on any reader edge while it is empty
    assign pop[g] = rd_valid[g] && (std_reg[g] ? rd_req[g] : rd_edge[g] && (!er_reg[g] || rd_req[g]));
    assign cnt_rd_after[g] = cnt[g] - (AW+1)'(pop[g]);
    assign cnt_wr_after[g] = cnt[g] + (AW+1)'(q_wr[g]);

    always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        mrst_q[g] <= 1'b0;
        rew_q[g] <= 1'b1;
      end else begin
        mrst_q[g] <= mrst_n[g];
        rew_q[g] <= (g == 0) ? i_ab_rewind_n : i_ba_rewind_n;
      end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        std_reg[g] <= 1'b1;
      end else if (mrst_rise[g]) begin
        std_reg[g] <= i_fall_through_select;
      end
    end

    sync_fifo #(.WIDTH(W), .DEPTH(DEPTH)) u_queue (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_clear(!mrst_n[g]),
      .i_rewind(std_reg[g] && rew_q[g] && !((g == 0) ? i_ab_rewind_n : i_ba_rewind_n)),
      .i_wr_valid(q_wr[g]),
      .o_wr_ready(),
      .i_wr_data(wr_data[g]),
      .o_rd_valid(rd_valid[g]),
      .i_rd_ready(pop[g]),
      .o_rd_data(rd_data[g]),
      .o_count(cnt[g])
    );

    always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        out_reg[g] <= '0;
      end else if (!mrst_n[g]) begin
        out_reg[g] <= '0;
      end else if (pop[g]) begin
        out_reg[g] <= rd_data[g];
      end
    end

    // Reader-side flags move only on the reading port's edge
    always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        er_reg[g] <= 1'b0;
        ne_n_reg[g] <= 1'b0;
      end else if (rd_edge[g]) begin
        if (!mrst_n[g]) begin
          er_reg[g] <= 1'b0;
          ne_n_reg[g] <= 1'b0;
        end else begin
          er_reg[g] <= std_reg[g] ? (cnt_rd_after[g] != '0) : (pop[g] || (er_reg[g] && !rd_req[g]));
          ne_n_reg[g] <= OW'(cnt_rd_after[g]) > ofs_reg[2*g+1];
        end
      end
    end

    // Writer-side flags; port B stays not-ready until offset loading ends
    always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        fr_reg[g] <= 1'b0;
        nf_n_reg[g] <= 1'b1;
      end else if (wr_edge[g]) begin
        if (!mrst_n[g]) begin
          fr_reg[g] <= 1'b0;
          nf_n_reg[g] <= 1'b1;
        end else begin
          fr_reg[g] <= (cnt_wr_after[g] != (AW+1)'(DEPTH)) && !(g == 1 && prog);
          nf_n_reg[g] <= (OW'(DEPTH) - OW'(cnt_wr_after[g])) > ofs_reg[2*g];
        end
      end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        box_reg[g] <= '0;
      end else if (wr_act[g] && wr_box[g] && box_full_n_reg[g]) begin
        box_reg[g] <= wr_data[g];
      end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        box_full_n_reg[g] <= 1'b1;
      end else if (!mrst_n[g]) begin
        box_full_n_reg[g] <= 1'b1;
      end else if (wr_act[g] && wr_box[g] && box_full_n_reg[g]) begin
        box_full_n_reg[g] <= 1'b0;
      end else if (rd_act[g] && rd_box[g]) begin
        box_full_n_reg[g] <= 1'b1;
      end
    end
  end

  // Data lines drive only while the port selects a read
  assign o_port_a_data_oe = !i_port_a_select_n && !i_port_a_dir;
  assign o_port_b_data_oe = !i_port_b_select_n && i_port_b_dir;

  // Registered output mux costs one i_clk of latency after a box select change
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_port_a_data <= '0;
      o_port_b_data <= '0;
    end else begin
      o_port_a_data <= i_port_a_box_sel ? box_reg[1] : out_reg[1];
      o_port_b_data <= i_port_b_box_sel ? box_reg[0] : out_reg[0];
    end
  end

  assign o_port_a_full_or_ready = fr_reg[0];
  assign o_port_b_full_or_ready = fr_reg[1];
  assign o_port_a_near_full_n = nf_n_reg[0];
  assign o_port_b_near_full_n = nf_n_reg[1];
  assign o_port_a_empty_or_ready = er_reg[1];
  assign o_port_b_empty_or_ready = er_reg[0];
  assign o_port_a_near_empty_n = ne_n_reg[1];
  assign o_port_b_near_empty_n = ne_n_reg[0];
  assign o_ab_box_full_n = box_full_n_reg[0];
  assign o_ba_box_full_n = box_full_n_reg[1];

  AST_A_FLAGS_HOLD: assert property (!a_edge |=> $stable(o_port_a_full_or_ready) && $stable(o_port_a_near_empty_n))
    else $error("Port A flag moved without a port A clock edge");
  AST_A_FLOAT: assert property ((i_port_a_select_n || i_port_a_dir) |-> !o_port_a_data_oe)
    else $error("Port A data driven while deselected or writing");
  AST_B_FLOAT: assert property ((i_port_b_select_n || !i_port_b_dir) |-> !o_port_b_data_oe)
    else $error("Port B data driven while deselected or writing");
  AST_NO_GO_NO_MAIL: assert property (!i_port_a_go |=> $stable(box_reg[0]))
    else $error("A-to-B mailbox changed with port A qualifier low");
  AST_AB_BOX_SET: assert property (wr_act[0] && wr_box[0] && o_ab_box_full_n && i_ab_master_reset_n
      |=> !o_ab_box_full_n ##1 (!o_ab_box_full_n || $past(rd_act[0] && rd_box[0]) || !$past(i_ab_master_reset_n)))
    else $error("A-to-B mailbox flag not taken low by write");
  AST_AB_BOX_CLR: assert property (rd_act[0] && rd_box[0] && !o_ab_box_full_n |=> o_ab_box_full_n)
    else $error("A-to-B mailbox flag not released by port B read");
  AST_BA_BOX_CLR: assert property (rd_act[1] && rd_box[1] && !o_ba_box_full_n |=> o_ba_box_full_n)
    else $error("B-to-A mailbox flag not released by port A read");
  AST_AB_RESET_OUT: assert property (!i_ab_master_reset_n |=> out_reg[0] == '0 && cnt[0] == '0)
    else $error("A-to-B reset left output register or count");
  AST_A_NEAR_EMPTY: assert property (a_edge && i_ba_master_reset_n && OW'(cnt_rd_after[1]) <= ofs_reg[3]
      |=> !o_port_a_near_empty_n)
    else $error("Port A near-empty high at or below offset");
endmodule

// ---- testbench/port_clocks.sv ----
`timescale 1ns/100ps
module port_clocks #(
  parameter int unsigned A_HALF = 3,
  parameter int unsigned B_HALF = 5
) (
  input wire logic i_clk,
  output logic o_port_a_clock,
  output logic o_port_b_clock
);
  int unsigned a_cnt_reg = 0;
  int unsigned b_cnt_reg = 0;
  initial begin
    o_port_a_clock = 1'b0;
    o_port_b_clock = 1'b0;
  end
  // Free-running from time zero; unequal periods make the ports drift against each other
  always @(posedge i_clk) begin
    a_cnt_reg <= (a_cnt_reg == A_HALF - 1) ? 0 : a_cnt_reg + 1;
    b_cnt_reg <= (b_cnt_reg == B_HALF - 1) ? 0 : b_cnt_reg + 1;
    if (a_cnt_reg == A_HALF - 1) o_port_a_clock <= ~o_port_a_clock;
    if (b_cnt_reg == B_HALF - 1) o_port_b_clock <= ~o_port_b_clock;
  end
endmodule

// ---- testbench/tb_bidir_sync_fifo_ports.sv ----
`timescale 1ns/100ps
module tb_bidir_sync_fifo_ports;
  logic i_clk, rst_b, pclk_a, pclk_b, sel_a_n, sel_b_n, go_a, go_b, dir_a, dir_b, box_a, box_b;
  logic [35:0] din_a, din_b, dout_a, dout_b;
  logic oe_a, oe_b, mr_ab_n, mr_ba_n, rw_ab_n, rw_ba_n, sel_lo, sel_hi, ft_sel;
  logic er_a, er_b, fr_a, fr_b, nf_a_n, nf_b_n, ne_a_n, ne_b_n, ab_full_n, ba_full_n;
  int miscompares = 0;
  int samples_checked = 0;
  int seed = 67491;
  logic [35:0] w [8];
  logic [13:0] ofs [4] = '{14'h0002, 14'h0001, 14'h0003, 14'h0002};

  port_clocks pclk (.i_clk(i_clk), .o_port_a_clock(pclk_a), .o_port_b_clock(pclk_b));
  bidir_sync_fifo_ports uut (.i_clk(i_clk), .i_rst_b(rst_b), .i_port_a_clock(pclk_a), .i_port_b_clock(pclk_b),
    .i_port_a_select_n(sel_a_n), .i_port_b_select_n(sel_b_n), .i_port_a_go(go_a), .i_port_b_go(go_b),
    .i_port_a_dir(dir_a), .i_port_b_dir(dir_b), .i_port_a_box_sel(box_a), .i_port_b_box_sel(box_b),
    .i_port_a_data(din_a), .o_port_a_data(dout_a), .o_port_a_data_oe(oe_a), .i_port_b_data(din_b),
    .o_port_b_data(dout_b), .o_port_b_data_oe(oe_b), .i_ab_master_reset_n(mr_ab_n),
    .i_ba_master_reset_n(mr_ba_n), .i_ab_rewind_n(rw_ab_n), .i_ba_rewind_n(rw_ba_n),
    .i_offset_sel_lo(sel_lo), .i_offset_sel_hi(sel_hi), .i_fall_through_select(ft_sel),
    .o_port_a_empty_or_ready(er_a), .o_port_b_empty_or_ready(er_b), .o_port_a_full_or_ready(fr_a),
    .o_port_b_full_or_ready(fr_b), .o_port_a_near_full_n(nf_a_n), .o_port_b_near_full_n(nf_b_n),
    .o_port_a_near_empty_n(ne_a_n), .o_port_b_near_empty_n(ne_b_n), .o_ab_box_full_n(ab_full_n),
    .o_ba_box_full_n(ba_full_n));

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  task automatic report_and_stop();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: flag got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [35:0] got, input logic [35:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: data got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic near_full_n(input int cnt, input int ofs_v);
    return (bidir_fifo_pkg::QUEUE_DEPTH - cnt) > ofs_v;
  endfunction

  function automatic logic [35:0] rnd36();
    logic [63:0] r;
    r = {$random(seed), $random(seed)};
    return r[35:0];
  endfunction

  // Standard-mode flag picture for given word counts in each queue
  task automatic chk_flags(input int ca, input int cb);
    chk_bit(fr_a, ca < 8);
    chk_bit(nf_a_n, near_full_n(ca, 2));
    chk_bit(er_b, ca > 0);
    chk_bit(ne_b_n, ca > 1);
    chk_bit(fr_b, cb < 8);
    chk_bit(nf_b_n, near_full_n(cb, 3));
    chk_bit(er_a, cb > 0);
    chk_bit(ne_a_n, cb > 2);
  endtask

  task automatic settle();
    repeat (30) @(posedge i_clk);
  endtask

  task automatic wait_lvl(input bit pb, input logic v);
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while ((pb ? pclk_b : pclk_a) !== v && n < 200);
    if (n >= 200) begin
      miscompares++;
      report_and_stop();
    end
  endtask

  // Controls are held across one whole port clock high phase, so exactly one port edge sees them
  task automatic xfer(input bit pb, input bit wr, input bit box, input bit sn, input bit go, input logic [35:0] d);
    wait_lvl(pb, 1'b0);
    if (pb) begin
      sel_b_n <= sn; go_b <= go; dir_b <= ~wr; box_b <= box; din_b <= d;
    end else begin
      sel_a_n <= sn; go_a <= go; dir_a <= wr; box_a <= box; din_a <= d;
    end
    wait_lvl(pb, 1'b1);
    chk_bit(pb ? oe_b : oe_a, !sn && !wr);
    wait_lvl(pb, 1'b0);
    if (pb) begin
      sel_b_n <= 1'b1; go_b <= 1'b0;
    end else begin
      sel_a_n <= 1'b1; go_a <= 1'b0;
    end
  endtask

  initial begin
    rst_b = 1'b0; mr_ab_n = 1'b0; mr_ba_n = 1'b0; rw_ab_n = 1'b1; rw_ba_n = 1'b1;
    sel_lo = 1'b0; sel_hi = 1'b0; ft_sel = 1'b1;
    sel_a_n = 1'b1; sel_b_n = 1'b1; go_a = 1'b0; go_b = 1'b0; dir_a = 1'b0; dir_b = 1'b1;
    box_a = 1'b0; box_b = 1'b0; din_a = 36'h0; din_b = 36'h0;
    repeat (10) @(posedge i_clk);
    rst_b <= 1'b1;
    repeat (50) @(posedge i_clk);
    mr_ab_n <= 1'b1;
    mr_ba_n <= 1'b1;
    settle();
    chk_word(dout_a, 36'h0);
    chk_word(dout_b, 36'h0);
    chk_bit(ab_full_n, 1'b1);
    chk_bit(ba_full_n, 1'b1);
    for (int i = 0; i < 4; i++) xfer(0, 1, 0, 0, 1, {22'h000000, ofs[i]});
    settle();
    chk_flags(0, 0);
    xfer(0, 1, 0, 1, 1, rnd36());
    xfer(0, 1, 0, 0, 0, rnd36());
    settle();
    chk_bit(er_b, 1'b0);
    for (int i = 0; i < 3; i++) w[i] = rnd36();
    for (int i = 0; i < 3; i++) xfer(0, 1, 0, 0, 1, w[i]);
    for (int p = 0; p < 2; p++) begin
      settle();
      for (int i = 0; i < 3; i++) begin
        xfer(1, 0, 0, 0, 1, 36'h0);
        chk_word(dout_b, w[i]);
      end
      if (p == 0) begin
        rw_ab_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        rw_ab_n <= 1'b1;
      end
    end
    for (int i = 0; i < 8; i++) begin
      w[i] = rnd36();
      xfer(0, 1, 0, 0, 1, w[i]);
      settle();
      chk_flags(i + 1, 0);
    end
    xfer(0, 1, 0, 0, 1, 36'hFFFFFFFFF);
    for (int i = 0; i < 8; i++) begin
      xfer(1, 0, 0, 0, 1, 36'h0);
      chk_word(dout_b, w[i]);
      settle();
      chk_flags(7 - i, 0);
    end
    for (int i = 0; i < 4; i++) begin
      w[i] = rnd36();
      xfer(1, 1, 0, 0, 1, w[i]);
      settle();
      chk_flags(0, i + 1);
    end
    // Second pass replays the same four words after a standard-mode rewind of the B-to-A queue
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 4; i++) begin
        xfer(0, 0, 0, 0, 1, 36'h0);
        chk_word(dout_a, w[i]);
        settle();
        chk_flags(0, 3 - i);
      end
      if (p == 0) begin
        rw_ba_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        rw_ba_n <= 1'b1;
        settle();
        chk_flags(0, 4);
      end
    end
    for (int p = 0; p < 2; p++) begin
      w[0] = rnd36();
      w[1] = rnd36();
      xfer(p, 1, 1, 0, 1, w[0]);
      xfer(p, 1, 1, 0, 1, w[1]);
      settle();
      chk_bit(p ? ba_full_n : ab_full_n, 1'b0);
      xfer(!p, 0, 1, 0, 1, 36'h0);
      chk_word(p ? dout_a : dout_b, w[0]);
      settle();
      chk_bit(p ? ba_full_n : ab_full_n, 1'b1);
      chk_flags(0, 0);
    end
    // A single reset with a non-zero select takes a preset offset and switches to fall-through
    mr_ab_n <= 1'b0;
    box_b <= 1'b0;
    sel_lo <= 1'b1;
    ft_sel <= 1'b0;
    repeat (50) @(posedge i_clk);
    mr_ab_n <= 1'b1;
    settle();
    chk_bit(nf_a_n, 1'b0);
    chk_word(dout_b, 36'h0);
    chk_bit(fr_a, 1'b1);
    w[0] = rnd36();
    xfer(0, 1, 0, 0, 1, w[0]);
    settle();
    chk_bit(er_b, 1'b1);
    chk_word(dout_b, w[0]);
    // Rewind must be ignored in fall-through: the read drains the only word and ready drops
    rw_ab_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    rw_ab_n <= 1'b1;
    settle();
    xfer(1, 0, 0, 0, 1, 36'h0);
    chk_word(dout_b, w[0]);
    settle();
    chk_bit(er_b, 1'b0);
    report_and_stop();
  end
endmodule
